// File: dld_defines.vh
// dma constants: register map, descriptor layout, bits, resets
// included by dld_dma.v only
`ifndef DLD_DEFINES_VH
`define DLD_DEFINES_VH

// register byte offsets
`define DLD_OFF_CTRL 6'h00
`define DLD_OFF_TX_LP 6'h04
`define DLD_OFF_RX_LP 6'h08
`define DLD_OFF_TX_POLL 6'h0c
`define DLD_OFF_RX_POLL 6'h10
`define DLD_OFF_RX_STAT 6'h14

// control register bits
`define DLD_CTL_TX_HALT 0
`define DLD_CTL_TX_RESUME 1
`define DLD_CTL_RX_HALT 2
`define DLD_CTL_RX_RESUME 3
`define DLD_CTL_IBE 4
`define DLD_CTL_TX_HALTED 8
`define DLD_CTL_RX_HALTED 9
`define DLD_CTL_TX_IDLE 10
`define DLD_CTL_RX_IDLE 11

// descriptor word offsets
`define DLD_D_NEXT 32'h0
`define DLD_D_STAT 32'h4
`define DLD_D_FADDR 32'h8
`define DLD_D_FLEN 32'hc
`define DLD_D_IMPLIED 32'h10

// descriptor bit positions
`define DLD_RX_OVF_BIT 13
`define DLD_RX_ERR_BIT 14
`define DLD_RX_DONE_BIT 15
`define DLD_TX_NOTIFY_BIT 15
`define DLD_TX_DONE_BIT 16
`define DLD_FRAG_LAST_BIT 31

// sizes and reset values
`define DLD_IMPLIED_CAP 13'h01f0
`define DLD_PTR_RST 32'h0
`define DLD_POLL_RST 8'h00

`endif

// File: dld_dma.v
// descriptor list dma: rx and tx engines, shared memory master, axi4-lite regs
// assumes a memory ack ending each held request, and fifo handshakes as ported
// Overview of operation
// - tx halt leaves pointer at completed descriptor
// - rx starts only when pointer nonzero, unhalted
// - clear rx status before descriptor fetch
// - done bit already set halts rx itself
// - self halt with polling rereads done bit
// - wait until oldest fifo frame is eligible
// - write frame to fragment or implied buffer
// - frame larger than buffers flags overflow
// - frame length field tracks bytes moved
// - frame end loads errors, sets done bit
// - drop frame from fifo, await completion
// - requested rx halt stops after drop
// - fetch next; zero polls or loads pointer
// - write status word back after next fetch
// - poll next until nonzero, then load
// - zero pointer unpolled idles until written
// - descriptors 16 to 512 bytes via pointers
// - tx fragments at any byte alignment
// - zero next ends list, 8-byte alignment; rx loads a next pointer found by polling with its low 3 bits kept
// - tx sets done bit, notify raises event
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "dld_defines.vh"

module dld_dma (
    // clock and reset
    input wire ref_clk_i,
    input wire rst_b_i,
    // axi4-lite slave
    input wire [7:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output wire s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output wire s_axi_wready_o,
    output reg [1:0] s_axi_bresp_o,
    output reg s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [7:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output wire s_axi_arready_o,
    output reg [31:0] s_axi_rdata_o,
    output reg [1:0] s_axi_rresp_o,
    output reg s_axi_rvalid_o,
    input wire s_axi_rready_i,
    // host memory master
    output wire mem_req_o,
    output wire mem_we_o,
    output wire [31:0] mem_addr_o,
    output wire [31:0] mem_wdata_o,
    output wire [3:0] mem_be_o,
    input wire mem_ack_i,
    input wire [31:0] mem_rdata_i,
    // receive fifo
    input wire rxf_eligible_i,
    input wire rxf_valid_i,
    input wire [31:0] rxf_data_i,
    input wire [2:0] rxf_bytes_i,
    input wire rxf_last_i,
    input wire rxf_err_i,
    output wire rxf_ready_o,
    output reg rxf_drop_o,
    input wire rxf_drop_done_i,
    // transmit fifo
    output wire txf_valid_o,
    output reg [31:0] txf_data_o,
    output wire [1:0] txf_lane_o,
    output wire [2:0] txf_bytes_o,
    output wire txf_last_o,
    input wire txf_ready_i,
    output reg tx_complete_o
);

////////////////////////////////////////
localparam R_IDLE = 16'h0001, R_CLR = 16'h0002, R_FST = 16'h0004, R_FA = 16'h0008;
localparam R_FL = 16'h0010, R_SHALT = 16'h0020, R_WAITF = 16'h0040, R_RDAT = 16'h0080;
localparam R_RWR = 16'h0100, R_DONE = 16'h0200, R_DISC = 16'h0400, R_HALT = 16'h0800;
localparam R_NXT = 16'h1000, R_WB = 16'h2000, R_PWAIT = 16'h4000, R_PNXT = 16'h8000;
localparam T_IDLE = 10'h001, T_CTL = 10'h002, T_FA = 10'h004, T_FL = 10'h008, T_MOV = 10'h010;
localparam T_PUSH = 10'h020, T_DONE = 10'h040, T_HALT = 10'h080, T_NXT = 10'h100, T_PW = 10'h200;

function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
        for (i = 0; i < 4; i = i + 1) begin
            merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    end
endfunction

// bytes from a lane to word end, capped by remainder
function [2:0] chunk;
    input [1:0] lane;
    input [12:0] rem;
    reg [2:0] room;
    begin
        room = 3'h4 - {1'b0, lane};
        chunk = (rem < {10'h000, room}) ? rem[2:0] : room;
    end
endfunction

function [3:0] be_of;
    input [2:0] n;
    begin
        be_of = (4'h1 << n) - 4'h1;
    end
endfunction

reg [15:0] rst_q;
reg [9:0] tst;
reg tx_halt_req, rx_halt_req, ibe;
reg [31:0] tx_lp, rx_lp;
reg [7:0] tx_poll, rx_poll;
reg [31:0] rx_status;
wire s_wr_ctl;

////////////////////////////////////////
// shared memory port; grant held by its owner until ack
reg lock_v, lock_rx;
wire rx_rq = |(rst_q & (R_FST | R_FA | R_FL | R_RWR | R_NXT | R_WB | R_PNXT));
wire tx_rq = |(tst & (T_CTL | T_FA | T_FL | T_MOV | T_DONE | T_NXT));
wire sel_rx = lock_v ? lock_rx : rx_rq;
wire rx_ack = mem_ack_i & sel_rx;
wire tx_ack = mem_ack_i & ~sel_rx;

always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        lock_v <= 1'b0;
        lock_rx <= 1'b0;
    end else if (mem_ack_i) begin
        lock_v <= 1'b0;
    end else if (mem_req_o && !lock_v) begin
        lock_v <= 1'b1;
        lock_rx <= sel_rx;
    end
end

////////////////////////////////////////
// receive engine
reg [31:0] rx_cur, rx_fa, rx_nxt, rx_word;
reg [12:0] rx_fl, rx_cnt;
reg [2:0] rx_nb;
reg rx_lastw;
reg [7:0] rx_pcnt;
wire [12:0] rx_cap = ibe ? `DLD_IMPLIED_CAP : rx_fl;
wire [31:0] rx_base = ibe ? rx_cur + `DLD_D_IMPLIED : rx_fa;
wire rx_fits = ({1'b0, rx_cnt} + {11'h000, rxf_bytes_i}) <= {1'b0, rx_cap};
assign rxf_ready_o = (rst_q == R_RDAT) & rxf_valid_i;
wire rx_resume = s_wr_ctl & s_axi_wdata_i[`DLD_CTL_RX_RESUME];
wire rx_wb_ld = (rst_q == R_WB) & rx_ack & ~((rx_nxt == 32'h0) & (rx_poll != 8'h00));
wire rx_pl_ld = (rst_q == R_PNXT) & rx_ack & (mem_rdata_i != 32'h0);
wire rx_ld = rx_wb_ld | rx_pl_ld;
wire [31:0] rx_ld_val = rx_wb_ld ? rx_nxt : mem_rdata_i;

always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        rst_q <= R_IDLE;
        rx_cur <= 32'h0;
        rx_fa <= 32'h0;
        rx_fl <= 13'h0;
        rx_nxt <= 32'h0;
        rx_word <= 32'h0;
        rx_cnt <= 13'h0;
        rx_nb <= 3'h0;
        rx_lastw <= 1'b0;
        rx_pcnt <= 8'h0;
        rx_status <= 32'h0;
        rxf_drop_o <= 1'b0;
    end else begin
        rxf_drop_o <= 1'b0;
        case (rst_q)
            R_IDLE: if (rx_lp != 32'h0 && !rx_halt_req) begin
                rx_cur <= rx_lp; // private copy shields pointer writes
                rst_q <= R_CLR;
            end
            R_CLR: begin
                rx_status <= 32'h0;
                rx_cnt <= 13'h0;
                rst_q <= R_FST;
            end
            R_FST: if (rx_ack) begin
                if (mem_rdata_i[`DLD_RX_DONE_BIT]) begin
                    rx_pcnt <= rx_poll;
                    rst_q <= R_SHALT;
                end else begin
                    rst_q <= R_FA;
                end
            end
            R_FA: if (rx_ack) begin
                rx_fa <= mem_rdata_i;
                rst_q <= R_FL;
            end
            R_FL: if (rx_ack) begin
                rx_fl <= mem_rdata_i[12:0];
                rst_q <= R_WAITF;
            end
            R_SHALT: begin
                // zero poll interval: stays until software resumes
                if (rx_resume) begin
                    rst_q <= R_FST;
                end else if (rx_poll != 8'h00) begin
                    if (rx_pcnt <= 8'h01) begin
                        rst_q <= R_FST;
                    end else begin
                        rx_pcnt <= rx_pcnt - 8'h01;
                    end
                end
            end
            R_WAITF: if (rxf_eligible_i) begin
                rst_q <= R_RDAT;
            end
            R_RDAT: if (rxf_valid_i) begin
                rx_word <= rxf_data_i;
                rx_nb <= rxf_bytes_i;
                rx_lastw <= rxf_last_i;
                if (rxf_last_i && rxf_err_i) begin
                    rx_status[`DLD_RX_ERR_BIT] <= 1'b1;
                end
                if (rx_fits && !rx_status[`DLD_RX_OVF_BIT]) begin
                    rst_q <= R_RWR;
                end else begin
                    rx_status[`DLD_RX_OVF_BIT] <= 1'b1; // excess is dropped
                    if (rxf_last_i) begin
                        rst_q <= R_DONE;
                    end
                end
            end
            R_RWR: if (rx_ack) begin
                rx_cnt <= rx_cnt + {10'h000, rx_nb};
                rx_status[12:0] <= rx_cnt + {10'h000, rx_nb};
                rst_q <= rx_lastw ? R_DONE : R_RDAT;
            end
            R_DONE: begin
                rx_status[`DLD_RX_DONE_BIT] <= 1'b1;
                rxf_drop_o <= 1'b1;
                rst_q <= R_DISC;
            end
            R_DISC: if (rxf_drop_done_i) begin
                rst_q <= rx_halt_req ? R_HALT : R_NXT;
            end
            R_HALT: if (rx_resume) begin
                rst_q <= R_NXT;
            end
            R_NXT: if (rx_ack) begin
                rx_nxt <= {mem_rdata_i[31:3], 3'h0};
                rst_q <= R_WB;
            end
            R_WB: if (rx_ack) begin
                rx_pcnt <= rx_poll;
                rst_q <= rx_wb_ld ? R_IDLE : R_PWAIT;
            end
            R_PWAIT: begin
                if (rx_pcnt <= 8'h01) begin
                    rst_q <= R_PNXT;
                end else begin
                    rx_pcnt <= rx_pcnt - 8'h01;
                end
            end
            R_PNXT: if (rx_ack) begin
                rx_pcnt <= rx_poll;
                rst_q <= rx_pl_ld ? R_IDLE : R_PWAIT;
            end
            default: rst_q <= R_IDLE;
        endcase
    end
end

////////////////////////////////////////
// transmit engine
reg [31:0] tx_cur, tx_ctl, tx_fa;
reg [12:0] tx_rem;
reg tx_flast;
reg [5:0] tx_idx;
reg [7:0] tx_pcnt;
wire [31:0] tx_fo = {23'h0, tx_idx, 3'h0};
wire [2:0] tx_nb = chunk(tx_fa[1:0], tx_rem);
wire tx_resume = s_wr_ctl & s_axi_wdata_i[`DLD_CTL_TX_RESUME];
wire tx_nz = mem_rdata_i[31:3] != 29'h0;
wire tx_ld = (tst == T_NXT) & tx_ack & (tx_nz | (tx_poll == 8'h00));
assign txf_valid_o = tst == T_PUSH;
assign txf_lane_o = tx_fa[1:0];
assign txf_bytes_o = tx_nb;
assign txf_last_o = tx_flast & (tx_rem == {10'h000, tx_nb});

always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        tst <= T_IDLE;
        tx_cur <= 32'h0;
        tx_ctl <= 32'h0;
        tx_fa <= 32'h0;
        tx_rem <= 13'h0;
        tx_flast <= 1'b0;
        tx_idx <= 6'h0;
        tx_pcnt <= 8'h0;
        txf_data_o <= 32'h0;
        tx_complete_o <= 1'b0;
    end else begin
        tx_complete_o <= 1'b0;
        case (tst)
            T_IDLE: if (tx_lp != 32'h0 && !tx_halt_req) begin
                tx_cur <= tx_lp;
                tx_idx <= 6'h0;
                tst <= T_CTL;
            end
            T_CTL: if (tx_ack) begin
                tx_ctl <= mem_rdata_i;
                tst <= T_FA;
            end
            T_FA: if (tx_ack) begin
                tx_fa <= mem_rdata_i; // any byte alignment
                tst <= T_FL;
            end
            T_FL: if (tx_ack) begin
                tx_rem <= mem_rdata_i[12:0];
                tx_flast <= mem_rdata_i[`DLD_FRAG_LAST_BIT];
                tx_idx <= tx_idx + 6'h01;
                if (mem_rdata_i[12:0] != 13'h0) begin
                    tst <= T_MOV;
                end else begin
                    tst <= mem_rdata_i[`DLD_FRAG_LAST_BIT] ? T_DONE : T_FA;
                end
            end
            T_MOV: if (tx_ack) begin
                txf_data_o <= mem_rdata_i;
                tst <= T_PUSH;
            end
            T_PUSH: if (txf_ready_i) begin
                tx_fa <= tx_fa + {29'h0, tx_nb};
                tx_rem <= tx_rem - {10'h000, tx_nb};
                if (tx_rem == {10'h000, tx_nb}) begin
                    tst <= tx_flast ? T_DONE : T_FA;
                end else begin
                    tst <= T_MOV;
                end
            end
            T_DONE: if (tx_ack) begin
                tx_complete_o <= tx_ctl[`DLD_TX_NOTIFY_BIT];
                tst <= tx_halt_req ? T_HALT : T_NXT; // pointer not yet advanced
            end
            T_HALT: if (tx_resume) begin
                tst <= T_NXT;
            end
            T_NXT: if (tx_ack) begin
                tx_pcnt <= tx_poll;
                tst <= tx_ld ? T_IDLE : T_PW;
            end
            T_PW: begin
                if (tx_pcnt <= 8'h01) begin
                    tst <= T_NXT;
                end else begin
                    tx_pcnt <= tx_pcnt - 8'h01;
                end
            end
            default: tst <= T_IDLE;
        endcase
    end
end

////////////////////////////////////////
// memory request mux
reg [31:0] m_addr, m_wdata;
reg [3:0] m_be;
reg m_we;
always @* begin
    m_we = 1'b0;
    m_wdata = 32'h0;
    m_be = 4'hf;
    m_addr = 32'h0;
    if (sel_rx) begin
        case (rst_q)
            R_FST: m_addr = rx_cur + `DLD_D_STAT;
            R_FA: m_addr = rx_cur + `DLD_D_FADDR;
            R_FL: m_addr = rx_cur + `DLD_D_FLEN;
            R_RWR: begin
                m_we = 1'b1;
                m_addr = rx_base + {19'h0, rx_cnt};
                m_wdata = rx_word;
                m_be = be_of(rx_nb);
            end
            R_WB: begin
                m_we = 1'b1;
                m_addr = rx_cur + `DLD_D_STAT;
                m_wdata = rx_status;
            end
            default: m_addr = rx_cur + `DLD_D_NEXT;
        endcase
    end else begin
        case (tst)
            T_CTL: m_addr = tx_cur + `DLD_D_STAT;
            T_FA: m_addr = tx_cur + `DLD_D_FADDR + tx_fo;
            T_FL: m_addr = tx_cur + `DLD_D_FLEN + tx_fo;
            T_MOV: m_addr = {tx_fa[31:2], 2'h0};
            T_DONE: begin
                m_we = 1'b1;
                m_addr = tx_cur + `DLD_D_STAT;
                m_wdata = tx_ctl | (32'h1 << `DLD_TX_DONE_BIT);
            end
            default: m_addr = tx_cur + `DLD_D_NEXT;
        endcase
    end
end
assign mem_req_o = rx_rq | tx_rq;
assign mem_we_o = m_we;
assign mem_addr_o = m_addr;
assign mem_wdata_o = m_wdata;
assign mem_be_o = m_be;

////////////////////////////////////////
// axi4-lite slave; write address and data taken together
wire wr_go = s_axi_awvalid_i & s_axi_wvalid_i & ~s_axi_bvalid_o;
wire rd_go = s_axi_arvalid_i & ~s_axi_rvalid_o;
assign s_axi_awready_o = wr_go;
assign s_axi_wready_o = wr_go;
assign s_axi_arready_o = rd_go;
wire [5:0] wa = {s_axi_awaddr_i[5:2], 2'h0};
wire [5:0] ra = {s_axi_araddr_i[5:2], 2'h0};
assign s_wr_ctl = wr_go & (wa == `DLD_OFF_CTRL) & s_axi_wstrb_i[0];
wire wa_ok = (wa <= `DLD_OFF_RX_STAT) & (s_axi_awaddr_i[7:6] == 2'h0);
wire ra_ok = (ra <= `DLD_OFF_RX_STAT) & (s_axi_araddr_i[7:6] == 2'h0);
wire [31:0] wr_tx_lp = merge(tx_lp, s_axi_wdata_i, s_axi_wstrb_i);
wire [31:0] wr_rx_lp = merge(rx_lp, s_axi_wdata_i, s_axi_wstrb_i);
wire tx_halted = (tst == T_HALT) | ((tst == T_IDLE) & tx_halt_req);
wire rx_halted = (rst_q == R_HALT) | (rst_q == R_SHALT) | ((rst_q == R_IDLE) & rx_halt_req);
reg [31:0] rd_val;

always @* begin
    case (ra)
        `DLD_OFF_CTRL: rd_val = {20'h0, rst_q == R_IDLE, tst == T_IDLE, rx_halted, tx_halted,
                                 3'h0, ibe, 1'b0, rx_halt_req, 1'b0, tx_halt_req};
        `DLD_OFF_TX_LP: rd_val = tx_lp;
        `DLD_OFF_RX_LP: rd_val = rx_lp;
        `DLD_OFF_TX_POLL: rd_val = {24'h0, tx_poll};
        `DLD_OFF_RX_POLL: rd_val = {24'h0, rx_poll};
        `DLD_OFF_RX_STAT: rd_val = rx_status;
        default: rd_val = 32'h0;
    endcase
end

always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_bresp_o <= 2'h0;
        s_axi_rvalid_o <= 1'b0;
        s_axi_rresp_o <= 2'h0;
        s_axi_rdata_o <= 32'h0;
        tx_halt_req <= 1'b0;
        rx_halt_req <= 1'b0;
        ibe <= 1'b0;
        tx_lp <= `DLD_PTR_RST;
        rx_lp <= `DLD_PTR_RST;
        tx_poll <= `DLD_POLL_RST;
        rx_poll <= `DLD_POLL_RST;
    end else begin
        if (wr_go) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wa_ok ? 2'h0 : 2'h2;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
        if (rd_go) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o <= ra_ok ? 2'h0 : 2'h2;
            s_axi_rdata_o <= ra_ok ? rd_val : 32'h0;
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
        // resume beats halt in one write
        if (s_wr_ctl) begin
            ibe <= s_axi_wdata_i[`DLD_CTL_IBE];
            if (s_axi_wdata_i[`DLD_CTL_TX_RESUME]) begin
                tx_halt_req <= 1'b0;
            end else if (s_axi_wdata_i[`DLD_CTL_TX_HALT]) begin
                tx_halt_req <= 1'b1;
            end
            if (s_axi_wdata_i[`DLD_CTL_RX_RESUME]) begin
                rx_halt_req <= 1'b0;
            end else if (s_axi_wdata_i[`DLD_CTL_RX_HALT]) begin
                rx_halt_req <= 1'b1;
            end
        end
        // software pointer write beats engine load
        if (wr_go && wa == `DLD_OFF_TX_LP) begin
            tx_lp <= {wr_tx_lp[31:3], 3'h0};
        end else if (tx_ld) begin
            tx_lp <= {mem_rdata_i[31:3], 3'h0};
        end
        if (wr_go && wa == `DLD_OFF_RX_LP) begin
            rx_lp <= {wr_rx_lp[31:3], 3'h0};
        end else if (rx_ld) begin
            rx_lp <= rx_ld_val;
        end
        if (wr_go && wa == `DLD_OFF_TX_POLL && s_axi_wstrb_i[0]) begin
            tx_poll <= s_axi_wdata_i[7:0];
        end
        if (wr_go && wa == `DLD_OFF_RX_POLL && s_axi_wstrb_i[0]) begin
            rx_poll <= s_axi_wdata_i[7:0];
        end
    end
end

endmodule // dld_dma

`default_nettype wire

// File: dld_dma_checker.sv
// dld_dma checker: bus, memory and fifo handshakes
// assumes one clock and the dma's async low reset
`timescale 1ns/1ps
`default_nettype none
module dld_dma_checker (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // register bus
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_bvalid_o,
    input wire logic [1:0] s_axi_bresp_o,
    // memory port
    input wire logic mem_req_o,
    input wire logic mem_we_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic [31:0] mem_wdata_o,
    input wire logic mem_ack_i,
    // fifos
    input wire logic rxf_last_i,
    input wire logic rxf_ready_o,
    input wire logic rxf_drop_o,
    input wire logic txf_valid_o,
    input wire logic [31:0] txf_data_o,
    input wire logic txf_ready_i,
    input wire logic tx_complete_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////
    sequence s_last_word;
        rxf_ready_o && rxf_last_i;
    endsequence
    sequence s_notify_done;
        mem_ack_i && mem_we_o && mem_wdata_o[16] && mem_wdata_o[15];
    endsequence
    a_write_answer: assert property (s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o |=> s_axi_bvalid_o)
        else $error("write not answered");
    a_bresp_stands: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped");
    a_mem_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
        && $stable(mem_wdata_o) && $stable(mem_we_o))
        else $error("memory request changed early");
    a_word_written: assert property (rxf_ready_o |-> ##[0:20] (mem_ack_i && mem_we_o))
        else $error("received word not written");
    a_drop_after_last: assert property (s_last_word |-> ##[1:40] rxf_drop_o)
        else $error("no drop after last word");
    a_drop_single: assert property (rxf_drop_o |=> !rxf_drop_o)
        else $error("drop longer than one cycle");
    a_notify_event: assert property (s_notify_done |-> ##[0:8] tx_complete_o)
        else $error("no completion event");
    a_txf_hold: assert property (txf_valid_o && !txf_ready_i |=> txf_valid_o && $stable(txf_data_o))
        else $error("tx word changed while stalled");
endmodule // dld_dma_checker
bind dld_dma dld_dma_checker u_dld_dma_checker (.ref_clk_i, .rst_b_i, .s_axi_awvalid_i, .s_axi_wvalid_i,
    .s_axi_bready_i, .s_axi_bvalid_o, .s_axi_bresp_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o,
    .mem_ack_i, .rxf_last_i, .rxf_ready_o, .rxf_drop_o, .txf_valid_o, .txf_data_o, .txf_ready_i, .tx_complete_o);
`default_nettype wire

// File: dld_host_mem.sv
// host memory model, 4 kbyte, behind the dma port
// assumes requests held to ack; answers fast and slow by turns
`timescale 1ns/1ps
`default_nettype none
module dld_host_mem (
    // clock
    input wire logic clk_i,
    // request
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] be_i,
    // answer
    output var logic ack_o = 1'b0,
    output var logic [31:0] rdata_o = 32'h0
);
    logic [31:0] mem [0:1023]; // descriptors 8-byte aligned
    logic [1:0] cnt = 2'h0;
    logic slow = 1'b0;
    ////////////////////////////////////////
    always @(posedge clk_i) begin
        ack_o <= 1'b0;
        // garbage off ack catches late sampling
        rdata_o <= ~rdata_o;
        if (req_i && !ack_o && cnt == {slow, slow}) begin
            ack_o <= 1'b1;
            cnt <= 2'h0;
            slow <= ~slow;
            for (int b = 0; b < 4; b++) begin
                if (we_i && be_i[b]) mem[addr_i[11:2]][8*b +: 8] <= wdata_i[8*b +: 8];
            end
            if (!we_i) rdata_o <= mem[addr_i[11:2]];
        end else if (req_i && !ack_o) begin
            cnt <= cnt + 2'h1;
        end
    end
endmodule // dld_host_mem
`default_nettype wire

// File: tb_top.sv
// dld_dma bench: register tasks, rx frames, self halt, tx halt
// assumes the memory model and bound checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; $display("Error at %0t: %h vs %h", $time, a, b); end end
module tb_top;
    logic ref_clk_i = 1'b0, rst_b_i = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rword = 32'h0, rdata, mem_addr, mem_wdata, mem_rdata, txd, tx_word, d;
    logic [1:0] bresp, rresp, txlane, tx_lane, r;
    logic bvalid, rvalid, awready, wready, arready, mem_req, mem_we, mem_ack, drop, rrdy, txv, txlast, tx_done;
    logic [3:0] mem_be;
    logic [2:0] txbytes, tx_bytes;
    logic elig = 1'b0, rvld = 1'b0, rlast = 1'b0, rerr = 1'b0, drop_done = 1'b0, txf_ready = 1'b0;
    int err_count = 0, checks = 0, taken = 0, notes = 0;
    ////////////////////////////////////////
    dld_dma u_dld_dma (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .mem_req_o(mem_req), .mem_we_o(mem_we), .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_be_o(mem_be),
        .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata), .rxf_eligible_i(elig), .rxf_valid_i(rvld),
        .rxf_data_i(rword), .rxf_bytes_i(3'h4), .rxf_last_i(rlast), .rxf_err_i(rerr), .rxf_ready_o(rrdy),
        .rxf_drop_o(drop), .rxf_drop_done_i(drop_done), .txf_valid_o(txv), .txf_data_o(txd),
        .txf_lane_o(txlane), .txf_bytes_o(txbytes), .txf_last_o(txlast), .txf_ready_i(txf_ready),
        .tx_complete_o(tx_done));
    dld_host_mem u_dld_host_mem (.clk_i(ref_clk_i), .req_i(mem_req), .we_i(mem_we), .addr_i(mem_addr),
        .wdata_i(mem_wdata), .be_i(mem_be), .ack_o(mem_ack), .rdata_o(mem_rdata));
    always #20 ref_clk_i = ~ref_clk_i;
    // tx fifo stalls every other cycle; drop done a cycle late
    always @(posedge ref_clk_i) begin
        txf_ready <= ~txf_ready;
        drop_done <= drop;
        if (rrdy) taken <= taken + 1;
        if (tx_done) notes <= notes + 1;
        if (txv && txf_ready) begin
            tx_word <= txd;
            tx_lane <= txlane;
            tx_bytes <= txbytes;
        end
    end
    ////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge ref_clk_i); while (!awready);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge ref_clk_i); while (!bvalid);
        bready <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge ref_clk_i); while (!arready);
        arvalid <= 1'b0;
        do @(posedge ref_clk_i); while (!rvalid);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
        @(posedge ref_clk_i);
    endtask
    task automatic push(input logic [31:0] w, input logic last, input logic err);
        rword <= w;
        rlast <= last;
        rerr <= err;
        rvld <= 1'b1;
        do @(posedge ref_clk_i); while (!rrdy);
        if (last) rvld <= 1'b0;
    endtask
    task automatic desc(input int i, input logic [31:0] n, s, a, l);
        u_dld_host_mem.mem[i] = n;
        u_dld_host_mem.mem[i+1] = s;
        u_dld_host_mem.mem[i+2] = a;
        u_dld_host_mem.mem[i+3] = l;
    endtask
    task automatic poll_ctl(input int b, input logic v);
        rd(8'h00);
        for (int i = 0; i < 60 && d[b] !== v; i++) rd(8'h00);
    endtask
    task automatic summarize();
        if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        err_count++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        @(posedge ref_clk_i);
        rd(8'h04); `CHK(d, 32'h0)
        rd(8'h18); `CHK(r, 2'h2)
        desc(64, 32'h0, 32'h0, 32'h400, 32'h8000_0008);
        wr(8'h08, 32'h100);
        fork
            push(32'h1122_3344, 1'b0, 1'b0);
            begin
                repeat (60) @(posedge ref_clk_i);
                `CHK(taken, 0)
                elig <= 1'b1;
            end
        join
        push(32'h5566_7788, 1'b1, 1'b1);
        wait (u_dld_host_mem.mem[65][15] === 1'b1);
        @(posedge ref_clk_i);
        `CHK(u_dld_host_mem.mem[256], 32'h1122_3344)
        `CHK(u_dld_host_mem.mem[257], 32'h5566_7788)
        `CHK(u_dld_host_mem.mem[65], 32'h0000_c008)
        rd(8'h14); `CHK(d, 32'h0000_c008)
        rd(8'h08); `CHK(d, 32'h0)
        // descriptor already done: engine must halt itself
        desc(80, 32'h0, 32'h8000, 32'h400, 32'h8000_0008);
        wr(8'h08, 32'h140);
        poll_ctl(9, 1'b1);
        `CHK(d[9], 1'b1)
        rd(8'h14); `CHK(d, 32'h0)
        wr(8'h10, 32'h8);
        u_dld_host_mem.mem[81] = 32'h0;
        poll_ctl(9, 1'b0);
        `CHK(d[9], 1'b0)
        // tx fragment at an odd byte address, halted right after start
        desc(128, 32'h0, 32'h8000, 32'h501, 32'h8000_0003);
        u_dld_host_mem.mem[320] = 32'hdead_beef;
        wr(8'h04, 32'h200);
        wr(8'h00, 32'h1);
        poll_ctl(8, 1'b1);
        rd(8'h04); `CHK(d, 32'h200)
        `CHK(u_dld_host_mem.mem[129], 32'h0001_8000)
        `CHK(notes, 1)
        `CHK(tx_word, 32'hdead_beef)
        `CHK(tx_lane, 2'h1)
        `CHK(tx_bytes, 3'h3)
        wr(8'h00, 32'h2);
        poll_ctl(10, 1'b1);
        rd(8'h04); `CHK(d, 32'h0)
        summarize();
    end
endmodule // tb_top
`default_nettype wire
